// file: shared/acsp_pkg.sv
// constants, register map and reset values of the cell slave port
// assumes a single 10 MHz bus clock; link pins are sampled by it
//
// What this block does
// - on own transmit address, drive tx cell-available showing a ready cell
// - once enabled, send cell bytes on tx data, first byte with start-of-cell
// - tx queue event high while room for a whole cell-packet remains
// - tx queue takes 32-bit words; fourteen words make one cell-packet
// - first word write of a cell clears the tx queue event
// - tx event returns at once if room for another cell-packet remains
// - tx cell-available only while a complete cell sits in the queue or a cell is still being sent
// - without a following cell, drop tx cell-available the cycle after cell end
// - with tx enable inactive, hold off the next byte and next cell
// - rx queue is drained by 32-bit word reads on the rx event
// - rx cell-available one cycle after our address, high if cell space exists
// - capture from rx start-of-cell, pack bytes to words, store in rx queue
// - rx queue event high once a complete cell is held
// - first read of a cell clears the rx queue event
// - rx event returns only when the next complete cell is present
// - without space for another cell, drop rx cell-available from the second byte of the cell on
// - multi-phy mode bit enables addressing and resets to one
// - in multi-phy mode a 5-bit slave id sets our address on both buses
// - unselected, cell-available is not driven, nor tx start-of-cell and tx data unless tx_send is set
// - in single-phy mode the slave answers without any address
// - enables active low; rx sampled, tx driven on rising link clock edges
package acsp_pkg;
  localparam int          CELL_WORDS = 14;
  localparam int          CELL_BYTES = 56;
  localparam logic [3:0]  LAST_WORD  = 4'hd;
  localparam logic [5:0]  LAST_BYTE  = 6'h37;
  // register byte offsets
  localparam logic [7:0]  OFF_TXQ    = 8'h00;
  localparam logic [7:0]  OFF_RXQ    = 8'h04;
  localparam logic [7:0]  OFF_CTRL   = 8'h08;
  localparam logic [7:0]  OFF_STAT   = 8'h0c;
  // control fields
  localparam int          CTRL_SLAVE_ID_LSB = 0;
  localparam int          CTRL_MULTI_PHY_ENABLE_BIT = 8;
  localparam logic        RST_MULTI_PHY_ENABLE   = 1'b1;
  localparam logic [4:0]  RST_SLAVE_ID   = 5'h00;
  // status fields
  localparam int          STAT_TXEV_BIT   = 0;
  localparam int          STAT_RXEV_BIT   = 1;
  localparam int          STAT_TXCELL_LSB = 8;
  localparam int          STAT_RXCELL_LSB = 12;
  localparam int          STAT_TXCNT_LSB  = 16;
  localparam int          STAT_RXCNT_LSB  = 24;
endpackage

// file: hdl/acsp_sync.sv
// two-stage synchroniser for a group of link pins
// assumes the pins change independently of clk_i
`timescale 1ns/1ps
module acsp_sync
  import acsp_pkg::*;
#(
  parameter int W = 8
)
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // pins in, synchronised out
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } acsp_sync_st_t;

  acsp_sync_st_t s_r;
  acsp_sync_st_t s_nxt;

  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.s1 = pin_i;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign sync_o = s_r.s2;
endmodule

// file: hdl/acsp_wfifo.sv
// word queue with occupancy count
// assumes push is never presented while full, nor pop while empty
`timescale 1ns/1ps
module acsp_wfifo
  import acsp_pkg::*;
#(
  parameter int DW    = 32,
  parameter int DEPTH = 56,
  parameter int AW    = $clog2(DEPTH)
)
(
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // fill side
  input  wire logic          push_i,
  input  wire logic [DW-1:0] wdata_i,
  // drain side
  input  wire logic          pop_i,
  output logic      [DW-1:0] rdata_o,
  // state
  output logic               full_o,
  output logic               empty_o,
  output logic      [AW:0]   count_o
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } acsp_fifo_st_t;

  acsp_fifo_st_t s_r;
  acsp_fifo_st_t s_nxt;
  logic [DW-1:0] mem [DEPTH];
  logic          do_push;
  logic          do_pop;

  assign full_o  = (s_r.cnt == (AW+1)'(DEPTH));
  assign empty_o = (s_r.cnt == '0);
  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;

  always_comb
  begin
    s_nxt = s_r;
    if (do_push)
      s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + AW'(1);
    if (do_pop)
      s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + AW'(1);
    s_nxt.cnt = s_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  always_ff @(posedge clk_i)
  begin
    if (do_push)
      mem[s_r.wp] <= wdata_i;
  end

  assign rdata_o = mem[s_r.rp];
  assign count_o = s_r.cnt;
endmodule

// file: hdl/acsp_top.sv
// cell slave port: word queues on the bus side, byte link on the pins
// assumes link clocks far slower than clk_i; pins sampled through two flops
`timescale 1ns/1ps
module acsp_top
  import acsp_pkg::*;
#(
  parameter int QUEUE_WORDS = 56
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // queue events
  output logic             tx_queue_event_o,
  output logic             rx_queue_event_o,
  // transmit link
  input  wire logic        tx_link_clock_i,
  input  wire logic [4:0]  tx_addr_in_i,
  input  wire logic        tx_enable_n_i,
  output logic             tx_cell_avail_o,
  output logic             tx_cell_avail_oe_o,
  output logic             tx_start_of_cell_o,
  output logic      [7:0]  tx_data_out_o,
  output logic             tx_data_oe_o,
  // receive link
  input  wire logic        rx_link_clock_i,
  input  wire logic [4:0]  rx_addr_in_i,
  input  wire logic        rx_enable_n_i,
  input  wire logic        rx_start_of_cell_i,
  input  wire logic [7:0]  rx_data_in_i,
  output logic             rx_cell_avail_o,
  output logic             rx_cell_avail_oe_o
);
  localparam int QW = $clog2(QUEUE_WORDS) + 1;

  typedef struct packed {
    logic [31:0] rdata;
    logic        txev;
    logic        rxev;
    logic        multi_phy_enable;
    logic [4:0]  slave_id;
    logic [3:0]  tx_wcnt;
    logic [3:0]  tx_cells;
    logic [3:0]  rx_rcnt;
    logic [3:0]  rx_cells;
    logic        txc_prev;
    logic        rxc_prev;
    logic        tx_send;
    logic [5:0]  tx_bcnt;
    logic [31:0] tx_word;
    logic [7:0]  tx_data;
    logic        tx_soc;
    logic        tx_oe;
    logic        tx_clav;
    logic        tx_clav_oe;
    logic        rx_recv;
    logic [5:0]  rx_bcnt;
    logic [23:0] rx_word;
    logic        rx_clav;
    logic        rx_clav_oe;
  } acsp_st_t;

  localparam acsp_st_t ST_RST = '{multi_phy_enable: RST_MULTI_PHY_ENABLE, slave_id: RST_SLAVE_ID, default: '0};

  acsp_st_t s_r;
  acsp_st_t s_nxt;

  // synchronised pins
  logic [6:0]    tsync;
  logic [15:0]   rsync;
  logic          t_clk;
  logic [4:0]    t_addr;
  logic          t_enb_n;
  logic          r_clk;
  logic [4:0]    r_addr;
  logic          r_enb_n;
  logic          r_soc;
  logic [7:0]    r_data;

  // queue hookup
  logic          txq_push;
  logic          txq_pop;
  logic [31:0]   txq_rdata;
  logic          txq_full;
  logic [QW-1:0] txq_cnt;
  logic          rxq_push;
  logic [31:0]   rxq_wdata;
  logic          rxq_pop;
  logic [31:0]   rxq_rdata;
  logic          rxq_empty;
  logic [QW-1:0] rxq_cnt;

  // per-cycle decisions
  logic          txe;
  logic          rxe;
  logic          tx_match;
  logic          rx_match;
  logic          tx_first_wr;
  logic          rx_first_rd;
  logic          tx_done;
  logic          tx_start;
  logic          rx_done;
  logic          tx_room;
  logic          rx_room;
  logic [QW-1:0] tx_pend;
  logic [QW-1:0] rx_rem;
  logic [5:0]    k;

  acsp_sync #(
    .W (7)
  ) u_tx_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({tx_enable_n_i, tx_addr_in_i, tx_link_clock_i}),
    .sync_o  (tsync)
  );

  acsp_sync #(
    .W (16)
  ) u_rx_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({rx_data_in_i, rx_start_of_cell_i, rx_enable_n_i,
               rx_addr_in_i, rx_link_clock_i}),
    .sync_o  (rsync)
  );

  assign t_clk   = tsync[0];
  assign t_addr  = tsync[5:1];
  assign t_enb_n = tsync[6];
  assign r_clk   = rsync[0];
  assign r_addr  = rsync[5:1];
  assign r_enb_n = rsync[6];
  assign r_soc   = rsync[7];
  assign r_data  = rsync[15:8];

  acsp_wfifo #(
    .DW    (32),
    .DEPTH (QUEUE_WORDS)
  ) u_txq (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .push_i  (txq_push),
    .wdata_i (reg_wdata_i),
    .pop_i   (txq_pop),
    .rdata_o (txq_rdata),
    .full_o  (txq_full),
    .empty_o (),
    .count_o (txq_cnt)
  );

  acsp_wfifo #(
    .DW    (32),
    .DEPTH (QUEUE_WORDS)
  ) u_rxq (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .push_i  (rxq_push),
    .wdata_i (rxq_wdata),
    .pop_i   (rxq_pop),
    .rdata_o (rxq_rdata),
    .full_o  (),
    .empty_o (rxq_empty),
    .count_o (rxq_cnt)
  );

  // rising link clock edges, seen on the bus clock
  assign txe = t_clk && !s_r.txc_prev;
  assign rxe = r_clk && !s_r.rxc_prev;
  assign tx_match = !s_r.multi_phy_enable || (t_addr == s_r.slave_id);
  assign rx_match = !s_r.multi_phy_enable || (r_addr == s_r.slave_id);

  // space left once the cell being written is finished
  assign tx_pend = (s_r.tx_wcnt == 4'h0) ? '0 : QW'(CELL_WORDS) - QW'(s_r.tx_wcnt);
  assign tx_room = (QW'(QUEUE_WORDS) - txq_cnt) >= (tx_pend + QW'(CELL_WORDS));
  assign rx_rem  = s_r.rx_recv ? QW'(CELL_WORDS) - QW'(s_r.rx_bcnt[5:2]) : '0;
  assign rx_room = (QW'(QUEUE_WORDS) - rxq_cnt) >= (rx_rem + QW'(CELL_WORDS));

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.rdata = '0;
    txq_push    = 1'b0;
    txq_pop     = 1'b0;
    rxq_push    = 1'b0;
    rxq_pop     = 1'b0;
    rxq_wdata   = '0;
    tx_first_wr = 1'b0;
    rx_first_rd = 1'b0;
    tx_done     = 1'b0;
    tx_start    = 1'b0;
    rx_done     = 1'b0;
    k           = 6'h00;

    // register writes
    if (reg_wr_i && reg_addr_i == OFF_TXQ && !txq_full)
    begin
      txq_push    = 1'b1;
      tx_first_wr = (s_r.tx_wcnt == 4'h0);
      if (s_r.tx_wcnt == LAST_WORD)
      begin
        s_nxt.tx_wcnt = 4'h0;
        tx_done       = 1'b1;
      end
      else
        s_nxt.tx_wcnt = s_r.tx_wcnt + 4'h1;
    end
    if (reg_wr_i && reg_addr_i == OFF_CTRL)
    begin
      s_nxt.multi_phy_enable = reg_wdata_i[CTRL_MULTI_PHY_ENABLE_BIT];
      s_nxt.slave_id = reg_wdata_i[CTRL_SLAVE_ID_LSB +: 5];
    end

    // register reads, answered next cycle
    if (reg_rd_i)
    begin
      if (reg_addr_i == OFF_RXQ && !rxq_empty)
      begin
        rxq_pop     = 1'b1;
        s_nxt.rdata = rxq_rdata;
        rx_first_rd = (s_r.rx_rcnt == 4'h0);
        s_nxt.rx_rcnt = (s_r.rx_rcnt == LAST_WORD) ? 4'h0 : s_r.rx_rcnt + 4'h1;
      end
      else if (reg_addr_i == OFF_CTRL)
      begin
        s_nxt.rdata[CTRL_MULTI_PHY_ENABLE_BIT]      = s_r.multi_phy_enable;
        s_nxt.rdata[CTRL_SLAVE_ID_LSB +: 5] = s_r.slave_id;
      end
      else if (reg_addr_i == OFF_STAT)
      begin
        s_nxt.rdata[STAT_TXEV_BIT]        = s_r.txev;
        s_nxt.rdata[STAT_RXEV_BIT]        = s_r.rxev;
        s_nxt.rdata[STAT_TXCELL_LSB +: 4] = s_r.tx_cells;
        s_nxt.rdata[STAT_RXCELL_LSB +: 4] = s_r.rx_cells;
        s_nxt.rdata[STAT_TXCNT_LSB +: 8]  = 8'(txq_cnt);
        s_nxt.rdata[STAT_RXCNT_LSB +: 8]  = 8'(rxq_cnt);
      end
    end

    // transmit link
    s_nxt.txc_prev = t_clk;
    if (txe)
    begin
      s_nxt.tx_clav_oe = tx_match;
      s_nxt.tx_clav = (s_r.tx_cells != 4'h0)
                   || (s_r.tx_send && s_r.tx_bcnt != LAST_BYTE);
      // enable high freezes byte and start-of-cell
      if (s_r.tx_send && !t_enb_n && s_r.tx_bcnt != LAST_BYTE)
      begin
        s_nxt.tx_bcnt = s_r.tx_bcnt + 6'h01;
        s_nxt.tx_soc  = 1'b0;
        if (s_nxt.tx_bcnt[1:0] == 2'h0)
        begin
          txq_pop       = 1'b1;
          s_nxt.tx_data = txq_rdata[31:24];
          s_nxt.tx_word = {txq_rdata[23:0], 8'h00};
        end
        else
        begin
          s_nxt.tx_data = s_r.tx_word[31:24];
          s_nxt.tx_word = {s_r.tx_word[23:0], 8'h00};
        end
      end
      // last byte taken: next cell may follow back to back
      else if (!t_enb_n && tx_match && s_r.tx_cells != 4'h0)
      begin
        tx_start      = 1'b1;
        txq_pop       = 1'b1;
        s_nxt.tx_send = 1'b1;
        s_nxt.tx_bcnt = 6'h00;
        s_nxt.tx_soc  = 1'b1;
        s_nxt.tx_data = txq_rdata[31:24];
        s_nxt.tx_word = {txq_rdata[23:0], 8'h00};
      end
      else if (!t_enb_n)
      begin
        s_nxt.tx_send = 1'b0;
        s_nxt.tx_soc  = 1'b0;
      end
      s_nxt.tx_oe = tx_match || s_nxt.tx_send;
    end

    // receive link
    s_nxt.rxc_prev = r_clk;
    if (rxe)
    begin
      s_nxt.rx_clav_oe = rx_match;
      s_nxt.rx_clav    = rx_room;
      if (!r_enb_n && (r_soc || s_r.rx_recv))
      begin
        k = r_soc ? 6'h00 : s_r.rx_bcnt;
        if (k[1:0] == 2'h3)
        begin
          rxq_push      = 1'b1;
          rxq_wdata     = {s_r.rx_word, r_data};
          s_nxt.rx_word = '0;
        end
        else
          s_nxt.rx_word = {s_r.rx_word[15:0], r_data};
        if (k == LAST_BYTE)
        begin
          s_nxt.rx_recv = 1'b0;
          s_nxt.rx_bcnt = 6'h00;
          rx_done       = 1'b1;
        end
        else
        begin
          s_nxt.rx_recv = 1'b1;
          s_nxt.rx_bcnt = k + 6'h01;
        end
      end
    end

    // cell counts and events
    s_nxt.tx_cells = s_r.tx_cells + 4'(tx_done) - 4'(tx_start);
    s_nxt.rx_cells = s_r.rx_cells + 4'(rx_done) - 4'(rx_first_rd);
    s_nxt.txev = !tx_first_wr && tx_room;
    s_nxt.rxev = rx_first_rd ? rx_done : (s_nxt.rx_cells != 4'h0);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      s_r <= ST_RST;
    else
      s_r <= s_nxt;
  end

  assign reg_rdata_o        = s_r.rdata;
  assign tx_queue_event_o   = s_r.txev;
  assign rx_queue_event_o   = s_r.rxev;
  assign tx_cell_avail_o    = s_r.tx_clav;
  assign tx_cell_avail_oe_o = s_r.tx_clav_oe;
  assign tx_start_of_cell_o = s_r.tx_soc;
  assign tx_data_out_o      = s_r.tx_data;
  assign tx_data_oe_o       = s_r.tx_oe;
  assign rx_cell_avail_o    = s_r.rx_clav;
  assign rx_cell_avail_oe_o = s_r.rx_clav_oe;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_tx_go;
    txe && (!s_r.tx_send || s_r.tx_bcnt == LAST_BYTE) && !t_enb_n && tx_match
      && s_r.tx_cells != 4'h0;
  endsequence

  sequence s_tx_paused;
    txe && s_r.tx_send && t_enb_n;
  endsequence

  sequence s_rx_first;
    reg_rd_i && reg_addr_i == OFF_RXQ && !rxq_empty && s_r.rx_rcnt == 4'h0;
  endsequence

  AST_TX_START: assert property (s_tx_go |=> tx_start_of_cell_o && tx_data_oe_o)
    else $error("tx start without start-of-cell");

  AST_TX_EVT_CLR: assert property (tx_first_wr |=> !tx_queue_event_o)
    else $error("tx event not cleared by first word");

  AST_TX_EVT_BACK: assert property (tx_first_wr ##1 tx_room |=> tx_queue_event_o)
    else $error("tx event not regenerated");

  AST_TX_CLAV: assert property (s_r.tx_clav && !s_r.tx_send |-> s_r.tx_cells != 4'h0)
    else $error("tx cell-available without a cell");

  AST_TX_HOLD: assert property (s_tx_paused |=> $stable(tx_data_out_o) && s_r.tx_send)
    else $error("tx advanced while disabled");

  AST_TX_HIZ: assert property (txe && !tx_match && !s_r.tx_send |=> !tx_data_oe_o
    && !tx_cell_avail_oe_o)
    else $error("tx pins driven while unselected");

  AST_RX_CLAV: assert property (rxe && rx_match |=> rx_cell_avail_oe_o
    && rx_cell_avail_o == $past(rx_room))
    else $error("rx cell-available wrong after address");

  AST_RX_EVT_CLR: assert property (s_rx_first ##0 !rx_done |=> !rx_queue_event_o)
    else $error("rx event not cleared by first read");

  AST_RX_EVT_CELL: assert property (rx_queue_event_o |-> s_r.rx_cells != 4'h0)
    else $error("rx event without a complete cell");

  AST_MULTI_PHY_ENABLE_RST: assert property ($rose(rst_n_i) |-> s_r.multi_phy_enable)
    else $error("multi-phy bit not one after reset");
endmodule

// file: bench/acsp_atm_master.sv
// far-side cell bus master: polls, fetches and sends cells
// assumes a slave that samples the link pins with a faster clock
`timescale 1ns/1ps
module acsp_atm_master
(
  // transmit link
  output logic            tx_clk_o,
  output logic      [4:0] tx_addr_o,
  output logic            tx_en_n_o,
  input  wire logic       tx_avail_i,
  input  wire logic       tx_avail_oe_i,
  input  wire logic       tx_soc_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_data_oe_i,
  // receive link
  output logic            rx_clk_o,
  output logic      [4:0] rx_addr_o,
  output logic            rx_en_n_o,
  output logic            rx_soc_o,
  output logic      [7:0] rx_data_o,
  input  wire logic       rx_avail_i,
  input  wire logic       rx_avail_oe_i
);
  logic [7:0] got [56];
  logic       avail, oe, late_avail, post_avail, soc_bad, hold_bad;

  initial
  begin
    tx_clk_o = 1'h0;
    rx_clk_o = 1'h0;
    tx_addr_o = 5'h1f;
    rx_addr_o = 5'h1f;
    tx_en_n_o = 1'h1;
    rx_en_n_o = 1'h1;
    rx_soc_o = 1'h0;
    rx_data_o = 8'h5a;
    soc_bad = 1'h0;
    hold_bad = 1'h0;
  end

  // one link cycle, clock still outside frames
  task automatic cyc(input logic rx);
    #100;
    if (rx)
      rx_clk_o = 1'h1;
    else
      tx_clk_o = 1'h1;
    #400;
    rx_clk_o = 1'h0;
    tx_clk_o = 1'h0;
    #300;
  endtask

  task automatic tx_poll(input logic [4:0] a);
    tx_addr_o = a;
    tx_en_n_o = 1'h1;
    cyc(1'h0);
    avail = tx_avail_i;
    oe = tx_avail_oe_i;
  endtask

  task automatic tx_fetch(input logic [4:0] a, input int s);
    tx_poll(a);
    for (int i = 0; i < 56; i++)
    begin
      if (i == s)
      begin
        tx_en_n_o = 1'h1;
        cyc(1'h0);
        cyc(1'h0);
        if (tx_data_i !== got[i-1] || tx_soc_i !== (i == 1)) hold_bad = 1'h1;
      end
      tx_en_n_o = 1'h0;
      cyc(1'h0);
      got[i] = tx_data_i;
      if (tx_soc_i !== (i == 0) || tx_data_oe_i !== 1'h1) soc_bad = 1'h1;
    end
    tx_en_n_o = 1'h1;
    cyc(1'h0);
    post_avail = tx_avail_i;
    tx_addr_o = 5'h1f;
  endtask

  task automatic rx_poll(input logic [4:0] a);
    rx_addr_o = a;
    rx_en_n_o = 1'h1;
    cyc(1'h1);
    avail = rx_avail_i;
    oe = rx_avail_oe_i;
  endtask

  task automatic rx_send(input logic [4:0] a, input logic [1:0] c);
    rx_poll(a);
    for (int i = 0; i < 56; i++)
    begin
      rx_en_n_o = 1'h0;
      rx_soc_o = (i == 0);
      rx_data_o = {c, 6'(i)};
      cyc(1'h1);
      if (i == 51) late_avail = rx_avail_i;
    end
    rx_en_n_o = 1'h1;
    rx_soc_o = 1'h0;
    rx_data_o = ~rx_data_o;
    rx_addr_o = 5'h1f;
  endtask
endmodule

// file: bench/tb_acsp_top.sv
// self-checking bench of the cell slave port
// assumes the master model drives both link sides
`timescale 1ns/1ps
module tb_acsp_top
  import acsp_pkg::*;
;
  logic        clk_i, rst_n_i, reg_wr_i, reg_rd_i;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i;
  // driven by the ports of the design and of the master model
  wire  [7:0]  tx_data, rx_data;
  wire  [31:0] reg_rdata_o;
  wire         tx_ev, tx_clk, tx_en_n, tx_avail, tx_avail_oe, tx_soc, tx_oe;
  wire         rx_ev, rx_clk, rx_en_n, rx_soc, rx_avail, rx_avail_oe;
  wire  [4:0]  tx_addr, rx_addr;
  int          miscompares, checks;

  acsp_top dut
  (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tx_queue_event_o(tx_ev), .rx_queue_event_o(rx_ev),
    .tx_link_clock_i(tx_clk), .tx_addr_in_i(tx_addr), .tx_enable_n_i(tx_en_n),
    .tx_cell_avail_o(tx_avail), .tx_cell_avail_oe_o(tx_avail_oe),
    .tx_start_of_cell_o(tx_soc), .tx_data_out_o(tx_data), .tx_data_oe_o(tx_oe),
    .rx_link_clock_i(rx_clk), .rx_addr_in_i(rx_addr), .rx_enable_n_i(rx_en_n),
    .rx_start_of_cell_i(rx_soc), .rx_data_in_i(rx_data),
    .rx_cell_avail_o(rx_avail), .rx_cell_avail_oe_o(rx_avail_oe)
  );

  acsp_atm_master u_master
  (
    .tx_clk_o(tx_clk), .tx_addr_o(tx_addr), .tx_en_n_o(tx_en_n),
    .tx_avail_i(tx_avail), .tx_avail_oe_i(tx_avail_oe), .tx_soc_i(tx_soc),
    .tx_data_i(tx_data), .tx_data_oe_i(tx_oe), .rx_clk_o(rx_clk),
    .rx_addr_o(rx_addr), .rx_en_n_o(rx_en_n), .rx_soc_o(rx_soc),
    .rx_data_o(rx_data), .rx_avail_i(rx_avail), .rx_avail_oe_i(rx_avail_oe)
  );

  initial
  begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'h0;
    #1;
    chk(reg_rdata_o, exp);
  endtask

  task automatic wait_ev(input logic rx);
    for (int n = 0; n < 2000; n++)
    begin
      if ((rx ? rx_ev : tx_ev) === 1'h1) return;
      @(posedge clk_i);
      #1;
    end
    chk(32'h0, 32'h1);
    end_of_test();
  endtask

  function automatic logic [31:0] cw(input logic [1:0] c, input int w);
    return {c, 6'(4*w), c, 6'(4*w+1), c, 6'(4*w+2), c, 6'(4*w+3)};
  endfunction

  task automatic put_cell(input logic [1:0] c, input logic e);
    chk(32'(tx_ev), 32'h1);
    for (int w = 0; w < CELL_WORDS; w++)
    begin
      wr(OFF_TXQ, cw(c, w));
      if (w == 0)
      begin
        chk(32'(tx_ev), 32'h0);
        @(posedge clk_i);
        #1;
        chk(32'(tx_ev), 32'(e));
      end
    end
  endtask

  task automatic chk_cell(input logic [1:0] c);
    for (int b = 0; b < CELL_BYTES; b++)
      chk(32'(u_master.got[b]), 32'({c, 6'(b)}));
    chk(32'(u_master.soc_bad), 32'h0);
  endtask

  initial
  begin
    #5000000;
    chk(32'h0, 32'h1);
    end_of_test();
  end

  initial
  begin
    rst_n_i = 1'h0;
    reg_wr_i = 1'h0;
    reg_rd_i = 1'h0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    miscompares = 0;
    checks = 0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    #1;
    chk(32'(rx_ev), 32'h0);
    rd(OFF_CTRL, 32'h100);
    rd(8'h10, 32'h0);
    rd(OFF_TXQ, 32'h0);
    wr(OFF_CTRL, 32'h105);
    wr(8'h10, 32'hffffffff);
    rd(OFF_CTRL, 32'h105);
    u_master.tx_poll(5'h05);
    chk({30'h0, u_master.oe, u_master.avail}, 32'h2);
    u_master.tx_poll(5'h06);
    chk(32'(u_master.oe), 32'h0);
    u_master.rx_poll(5'h06);
    chk(32'(u_master.oe), 32'h0);
    put_cell(2'h1, 1'h1);
    u_master.tx_poll(5'h05);
    chk({30'h0, u_master.oe, u_master.avail}, 32'h3);
    u_master.tx_fetch(5'h05, 20);
    chk_cell(2'h1);
    chk(32'(u_master.hold_bad), 32'h0);
    chk(32'(u_master.post_avail), 32'h0);
    for (int c = 0; c < 4; c++)
      put_cell(2'(c), 1'(c < 3));
    chk(32'(tx_ev), 32'h0);
    rd(OFF_STAT, (32'h4 << STAT_TXCELL_LSB) | (32'(CELL_WORDS * 4) << STAT_TXCNT_LSB));
    u_master.tx_fetch(5'h05, 99);
    chk_cell(2'h0);
    chk(32'(u_master.post_avail), 32'h1);
    wait_ev(1'h0);
    for (int k = 0; k < 4; k++)
    begin
      u_master.rx_send(5'h05, 2'(k));
      chk({30'h0, u_master.oe, u_master.avail}, 32'h3);
      chk(32'(u_master.late_avail), 32'(k < 3));
      wait_ev(1'h1);
    end
    u_master.rx_poll(5'h05);
    chk({30'h0, u_master.oe, u_master.avail}, 32'h2);
    for (int k = 0; k < 4; k++)
    begin
      for (int w = 0; w < CELL_WORDS; w++)
      begin
        rd(OFF_RXQ, cw(2'(k), w));
        if (k == 3) chk(32'(rx_ev), 32'h0);
      end
      if (k < 3) wait_ev(1'h1);
    end
    rd(OFF_RXQ, 32'h0);
    wr(OFF_CTRL, 32'h0);
    u_master.tx_poll(5'h09);
    chk({30'h0, u_master.oe, u_master.avail}, 32'h3);
    u_master.rx_poll(5'h12);
    chk({30'h0, u_master.oe, u_master.avail}, 32'h3);
    end_of_test();
  end
endmodule
